// ### serial_flow_params.svh
`ifndef SERIAL_FLOW_PARAMS_SVH
`define SERIAL_FLOW_PARAMS_SVH

// System clock rate in Hz
`define CLK_HZ 100000000
// Link rates in bit/s
`define BAUD_DEFAULT 115200
`define BAUD_MIN 9600
`define BAUD_MAX 921600
// Width of the baud divisor field
`define DIV_W 14
// Divisor values derived from the clock and the link rates
`define DIV_RESET (`CLK_HZ / `BAUD_DEFAULT)
`define DIV_LARGEST (`CLK_HZ / `BAUD_MIN)
`define DIV_SMALLEST (`CLK_HZ / `BAUD_MAX)
// Character frame: eight data bits, no parity, one stop bit
`define DATA_BITS 8
`define LAST_BIT 3'h7

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_BAUD 12'h004
`define OFS_STATUS 12'h008

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_RESET 2'h0

// Status register bit positions
`define ST_RX_FULL 0
`define ST_TX_BUSY 1
`define ST_RTS_ON 2
`define ST_CTS_OFF 3
`define ST_OVERRUN 4
`define ST_FRAME_ERR 5

`endif

// ### serial_flow_pkg.sv
package serial_flow_pkg;

  // Handshake setting: bit 0 drives the clear-to-send pin,
  // bit 1 makes transmission wait on request-to-send
  typedef enum logic [1:0] {
    HS_DISABLED = 2'b00,
    HS_RTS = 2'b01,
    HS_CTS = 2'b10,
    HS_RTSCTS = 2'b11
  } handshake_t;

  // Character engine states, shared by transmitter and receiver
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_START = 2'b01,
    CH_DATA = 2'b10,
    CH_STOP = 2'b11
  } char_state_t;

endpackage

// ### flow_buf2.sv
module flow_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import serial_flow_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Entry storage in flip-flops
  logic [PW-1:0] wr_ptr, next_wr_ptr; // Next slot to fill
  logic [PW-1:0] rd_ptr, next_rd_ptr; // Oldest slot
  logic [CW-1:0] count, next_count; // Entries held
  logic next_in_ready, next_out_valid;
  logic [WIDTH-1:0] next_out_data; // Head word as it will stand next cycle
  logic push, pop;

  // Flags are registered so neither side sees a combinational path
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + CW'(push) - CW'(pop);
    next_in_ready = (next_count != CW'(DEPTH));
    next_out_valid = (next_count != '0);
    // Head word is registered so the consumer sees a flop, not a mux;
    // a word written into the slot that becomes the head is forwarded
    next_out_data = out_data;
    if (next_count != '0) begin
      if (push && wr_ptr == next_rd_ptr) begin
        next_out_data = in_data;
      end else begin
        next_out_data = mem[next_rd_ptr];
      end
    end
  end

  // Pointer and flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // Data slots carry no reset; valid guards their use
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge pclk) begin
        if (push && wr_ptr == PW'(i)) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

endmodule // flow_buf2

// ### serial_rx_core.sv
`include "serial_flow_params.svh"

module serial_rx_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rxd_sync,
  input wire logic [`DIV_W-1:0] div,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err
);
  import serial_flow_pkg::*;

  char_state_t state, next_state; // Receive sequence
  logic [`DIV_W-1:0] cnt, next_cnt; // Cycles to next sample point
  logic [2:0] bit_idx, next_bit_idx; // Data bit being taken
  logic [7:0] next_rx_data;
  logic next_rx_valid, next_rx_frame_err;

  // Sample at mid-bit: half a divisor after the falling start edge
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_rx_frame_err = 1'b0;
    case (state)
      CH_IDLE: begin
        if (!rxd_sync) begin
          next_state = CH_START;
          next_cnt = div >> 1;
        end
      end
      CH_START: begin
        if (cnt == '0) begin
          // A glitch shorter than half a bit is dropped here
          next_state = rxd_sync ? CH_IDLE : CH_DATA;
          next_cnt = div - 1'b1;
          next_bit_idx = '0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CH_DATA: begin
        if (cnt == '0) begin
          next_rx_data = {rxd_sync, rx_data[7:1]}; // LSB first
          next_cnt = div - 1'b1;
          next_bit_idx = bit_idx + 1'b1;
          if (bit_idx == `LAST_BIT) begin
            next_state = CH_STOP;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CH_STOP: begin
        if (cnt == '0) begin
          next_rx_valid = rxd_sync;
          next_rx_frame_err = !rxd_sync;
          next_state = CH_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = CH_IDLE;
      end
    endcase
  end

  // Receiver registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CH_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_frame_err <= next_rx_frame_err;
    end
  end

endmodule // serial_rx_core

// ### serial_port_flow.sv
`include "serial_flow_params.svh"

module serial_port_flow (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host stream toward the target
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Host stream from the target
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Target link pins
  output logic txd,
  input wire logic rxd,
  input wire logic target_rts_n,
  output logic target_cts_n_o,
  output logic target_cts_oe_n
);
  import serial_flow_pkg::*;

  localparam logic [`DIV_W-1:0] DIV_RST = `DIV_W'(`DIV_RESET);
  localparam logic [`DIV_W-1:0] DIV_HI = `DIV_W'(`DIV_LARGEST);
  localparam logic [`DIV_W-1:0] DIV_LO = `DIV_W'(`DIV_SMALLEST);

  // Pin synchronisers; the first stages feed only the second
  logic rxd_meta, rxd_sync;
  logic rts_meta, rts_sync_n;

  // Software-visible state
  handshake_t mode, next_mode; // Handshake setting
  logic [`DIV_W-1:0] div, next_div; // Cycles per bit
  logic overrun, next_overrun; // Receive word lost, sticky
  logic frame_err, next_frame_err; // Bad stop bit, sticky

  // APB answer state
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic acc, wr_en; // Access phase, write taking effect
  logic [31:0] status_word;
  logic [`DIV_W-1:0] div_req;

  // Transmit engine
  char_state_t tx_state, next_tx_state;
  logic [`DIV_W-1:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_shift, next_tx_shift;
  logic next_txd;
  logic txb_valid, txb_pop;
  logic [7:0] txb_data;
  logic send_ok;

  // Receive path
  logic core_valid, core_ferr;
  logic [7:0] core_data;
  logic rxb_ready;

  // Clear-to-send pin
  logic next_cts_n, next_cts_oe_n;

  // Two-stage synchronisers for the asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rts_meta <= 1'b1;
      rts_sync_n <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
      rts_meta <= target_rts_n;
      rts_sync_n <= rts_meta;
    end
  end

  // Status word shows the block's state and the target's request-to-send line
  always_comb begin
    status_word = '0;
    status_word[`ST_RX_FULL] = !rxb_ready;
    status_word[`ST_TX_BUSY] = (tx_state != CH_IDLE) || txb_valid;
    status_word[`ST_RTS_ON] = !rts_sync_n;
    status_word[`ST_CTS_OFF] = target_cts_n_o && !target_cts_oe_n;
    status_word[`ST_OVERRUN] = overrun;
    status_word[`ST_FRAME_ERR] = frame_err;
  end

  // Register decode and update; zero-wait answer in the access phase
  always_comb begin
    acc = psel && penable && pready;
    wr_en = acc && pwrite;
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = '0;
    next_mode = mode;
    next_div = div;
    // Out-of-range rates are pulled to the nearest legal one
    div_req = pwdata[`DIV_W-1:0];
    if (pwdata[31:`DIV_W] != '0 || div_req > DIV_HI) begin
      div_req = DIV_HI;
    end else if (div_req < DIV_LO) begin
      div_req = DIV_LO;
    end
    if (psel && !penable) begin
      case (paddr)
        `OFS_CTRL: begin
          next_prdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode;
        end
        `OFS_BAUD: begin
          next_prdata[`DIV_W-1:0] = div;
        end
        `OFS_STATUS: begin
          next_prdata = status_word;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en && paddr == `OFS_CTRL) begin
      next_mode = handshake_t'(pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    end
    if (wr_en && paddr == `OFS_BAUD) begin
      next_div = div_req;
    end
    // Write one to clear; a new event in the same cycle wins
    next_overrun = overrun;
    next_frame_err = frame_err;
    if (wr_en && paddr == `OFS_STATUS) begin
      if (pwdata[`ST_OVERRUN]) begin
        next_overrun = 1'b0;
      end
      if (pwdata[`ST_FRAME_ERR]) begin
        next_frame_err = 1'b0;
      end
    end
    if (core_valid && !rxb_ready) begin
      next_overrun = 1'b1;
    end
    if (core_ferr) begin
      next_frame_err = 1'b1;
    end
  end

  // Register and bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= HS_DISABLED;
      div <= DIV_RST;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      mode <= next_mode;
      div <= next_div;
      overrun <= next_overrun;
      frame_err <= next_frame_err;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Host words wait here so a paused link never drops one
  flow_buf2 #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_tx_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txb_valid),
    .out_ready(txb_pop),
    .out_data(txb_data)
  );

  // Transmit sequencer; permission is checked only in idle, so a
  // character already started always finishes
  always_comb begin
    // Request-to-send is honoured only when bit 1 of the setting is set
    send_ok = !mode[1] || !rts_sync_n;
    txb_pop = 1'b0;
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_shift = tx_shift;
    next_txd = txd;
    case (tx_state)
      CH_IDLE: begin
        next_txd = 1'b1;
        if (txb_valid && send_ok) begin
          txb_pop = 1'b1;
          next_tx_shift = txb_data;
          next_tx_state = CH_START;
          next_tx_cnt = div - 1'b1;
          next_txd = 1'b0;
        end
      end
      CH_START: begin
        if (tx_cnt == '0) begin
          next_tx_state = CH_DATA;
          next_tx_cnt = div - 1'b1;
          next_tx_bit = '0;
          next_txd = tx_shift[0];
          next_tx_shift = {1'b0, tx_shift[7:1]};
        end else begin
          next_tx_cnt = tx_cnt - 1'b1;
        end
      end
      CH_DATA: begin
        if (tx_cnt == '0) begin
          next_tx_cnt = div - 1'b1;
          if (tx_bit == `LAST_BIT) begin
            next_tx_state = CH_STOP;
            next_txd = 1'b1;
          end else begin
            next_tx_bit = tx_bit + 1'b1;
            next_txd = tx_shift[0];
            next_tx_shift = {1'b0, tx_shift[7:1]};
          end
        end else begin
          next_tx_cnt = tx_cnt - 1'b1;
        end
      end
      CH_STOP: begin
        // Withdrawn request-to-send does not cut this character short
        if (tx_cnt == '0) begin
          next_tx_state = CH_IDLE;
        end else begin
          next_tx_cnt = tx_cnt - 1'b1;
        end
      end
      default: begin
        next_tx_state = CH_IDLE;
        next_txd = 1'b1;
      end
    endcase
  end

  // Transmit registers; line idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= CH_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_shift <= '0;
      txd <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_shift <= next_tx_shift;
      txd <= next_txd;
    end
  end

  // Receiver shares the divisor so both directions run at one rate
  serial_rx_core u_rx_core (
    .pclk(pclk),
    .presetn(presetn),
    .rxd_sync(rxd_sync),
    .div(div),
    .rx_valid(core_valid),
    .rx_data(core_data),
    .rx_frame_err(core_ferr)
  );

  // Words from the target; its fill level drives clear-to-send
  flow_buf2 #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_rx_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(core_valid),
    .in_ready(rxb_ready),
    .in_data(core_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // Clear-to-send pin: driven only when bit 0 of the setting is set,
  // low means the target may send, high withdraws permission
  always_comb begin
    next_cts_oe_n = !mode[0];
    next_cts_n = !rxb_ready;
    if (!mode[0]) begin
      next_cts_n = 1'b1;
    end
  end

  // Clear-to-send registers; undriven out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_cts_n_o <= 1'b1;
      target_cts_oe_n <= 1'b1;
    end else begin
      target_cts_n_o <= next_cts_n;
      target_cts_oe_n <= next_cts_oe_n;
    end
  end

endmodule // serial_port_flow

// ### target_port.sv
// Behavioural target serial port facing the block's link pins
module target_port #(
  parameter int BIT_NS = 1080
) (
  input wire logic txd,
  output logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  input wire logic fc_en,
  input wire logic hold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$]; // Bytes taken off txd
  logic [7:0] sh; // Receive shift value
  assign rts_n = hold; // Low asks for data
  initial rxd = 1'h1;
  // Receiver keeps taking a byte even while holding off
  always begin
    @(negedge txd);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      sh[i] = txd;
    end
    #(BIT_NS);
    got.push_back(sh);
  end
  // Sender checks permission only between characters
  task automatic send(input logic [7:0] b);
    while (fc_en && cts_n !== 1'h0) #(BIT_NS);
    rxd = 1'h0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #(BIT_NS);
    end
    rxd = 1'h1;
    #(BIT_NS);
  endtask
endmodule // target_port

// ### serial_flow_chk.sv
module serial_flow_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic txd,
  input wire logic target_rts_n,
  input wire logic target_cts_n_o,
  input wire logic target_cts_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mode, next_mode; // Mirror of the handshake field
  logic [31:0] div, next_div; // Mirror of the divisor
  logic [17:0] hi, next_hi; // Cycles the request line stayed off
  logic wr; // A write lands this edge
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Mirrors follow completed writes, clamped as the slave does
  always_comb begin
    next_mode = mode;
    next_div = div;
    next_hi = target_rts_n ? hi + 18'h1 : 18'h0;
    if (target_rts_n && hi == 18'h3FFFF) next_hi = hi; // Saturate
    if (wr && paddr == 12'h000) next_mode = pwdata[1:0];
    if (wr && paddr == 12'h004) begin
      next_div = pwdata;
      if (pwdata > 32'h28B0) next_div = 32'h28B0;
      if (pwdata < 32'h6C) next_div = 32'h6C;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 2'h0;
      div <= 32'h364;
      hi <= 18'h0;
    end else begin
      mode <= next_mode;
      div <= next_div;
      hi <= next_hi;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_apb_zero_wait: assert property (s_setup |=> s_answer)
    else $error("no answer one cycle after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && paddr > 12'h008
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (pready && paddr == 12'h004 |-> !pslverr)
    else $error("mapped access refused");
  a_cts_undriven: assert property ((!mode[0]) [*3] |-> target_cts_oe_n)
    else $error("clear line driven");
  a_cts_driven: assert property (mode[0] [*3] |-> !target_cts_oe_n)
    else $error("clear line not driven");
  a_cts_on_full: assert property (!target_cts_oe_n && target_cts_n_o |-> rx_valid)
    else $error("clear withdrawn with empty buffer");
  a_tx_paused: assert property (mode[1] && hi > 18'(div * 11 + 8) |-> txd)
    else $error("sending while request off");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx byte lost in stall");
  a_reset_idle: assert property ($rose(presetn) |-> txd && tx_ready
    && target_cts_oe_n && !rx_valid) else $error("bad idle after reset");
endmodule // serial_flow_chk
bind serial_port_flow serial_flow_chk chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_data(rx_data), .txd(txd), .target_rts_n(target_rts_n),
  .target_cts_n_o(target_cts_n_o), .target_cts_oe_n(target_cts_oe_n));

// ### serial_port_hw_flow_control_bench.sv
module serial_port_hw_flow_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_flow_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] bv; // Baud value under test, written to the baud register
  logic tx_valid, tx_ready, rx_valid, rx_ready, txd, rxd, rts_n;
  logic [7:0] tx_data, rx_data;
  logic cts_n_o, cts_oe_n, cts_wire, fc_en, hold;
  logic [7:0] rxq[$]; // Bytes handed to the host
  logic [7:0] e[3]; // Bytes the target sends
  int n_mismatch, tests_run, seed;
  assign cts_wire = cts_oe_n ? 1'h1 : cts_n_o; // Pull-up when undriven
  serial_port_flow uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .txd(txd), .rxd(rxd), .target_rts_n(rts_n),
    .target_cts_n_o(cts_n_o), .target_cts_oe_n(cts_oe_n));
  target_port tp (.txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_wire),
    .fc_en(fc_en), .hold(hold));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Host side takes a byte whenever it offers ready
  always @(negedge pclk) begin
    if (rx_valid === 1'h1 && rx_ready === 1'h1) rxq.push_back(rx_data);
  end
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return v > 32'h28B0 ? 32'h28B0 : (v < 32'h6C ? 32'h6C : v);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x,
    input string m);
    tests_run++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Access holds until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) begin
      n_mismatch++;
      $display("BAD %0t apb no answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic push(input logic [7:0] b);
    int k;
    k = 0;
    @(posedge pclk);
    tx_valid <= 1'h1;
    tx_data <= b;
    // Byte is taken at the rising edge that sees tx_ready high
    do begin
      @(posedge pclk);
      k++;
    end while (tx_ready !== 1'h1 && k < 50);
    if (tx_ready !== 1'h1) begin
      n_mismatch++;
      $display("BAD %0t push not taken", $time);
    end
    tx_valid <= 1'h0;
  endtask
  task automatic until_n(input int n, input logic rxside);
    int k;
    k = 0;
    while ((rxside ? rxq.size() : tp.got.size()) < n && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    if ((rxside ? rxq.size() : tp.got.size()) < n) begin
      n_mismatch++;
      $display("BAD %0t byte count not reached", $time);
    end
  endtask
  // Host to target in one mode: running byte finishes, new one waits when bit 1 of the mode is set
  task automatic tx_case(input logic [1:0] m);
    int n0;
    logic [7:0] b;
    apb(1'h1, 12'h000, {30'h0, m});
    n0 = tp.got.size();
    b = 8'($random(seed));
    push(b);
    while (txd !== 1'h0) @(posedge pclk);
    hold <= 1'h1;
    until_n(n0 + 1, 1'h0);
    chk(tp.got[n0], b, "byte in flight");
    push(~b);
    repeat (3300) @(posedge pclk);
    chk(tp.got.size() - n0, m[1] ? 1 : 2, "tx gating");
    hold <= 1'h0;
    until_n(n0 + 2, 1'h0);
    chk(tp.got[n0 + 1], b ^ 8'hFF, "tx resumed");
    chk(cts_oe_n, !m[0], "cts enable");
    $display("test tx mode %0d done", m);
  endtask
  // Target to host with host stalled: throttle or overrun
  task automatic rx_case(input logic [1:0] m, input logic pfc);
    apb(1'h1, 12'h000, {30'h0, m});
    fc_en <= pfc;
    rxq.delete();
    for (int j = 0; j < 3; j++) e[j] = 8'($random(seed));
    fork
      for (int j = 0; j < 3; j++) tp.send(e[j]);
    join_none
    repeat (4400) @(posedge pclk);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[0], 1'h1, "rx full");
    // Withdrawn when driven and full; parked high when undriven
    chk(cts_n_o, 1'h1, "cts withdrawn");
    chk(rd[4], !pfc, "overrun");
    apb(1'h1, 12'h008, 32'h10);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[4], 1'h0, "overrun cleared");
    rx_ready <= 1'h1;
    until_n(pfc ? 3 : 2, 1'h1);
    repeat (1200) @(posedge pclk);
    chk(rxq.size(), pfc ? 3 : 2, "rx count");
    for (int j = 0; j < rxq.size(); j++) chk(rxq[j], e[j], "rx byte");
    chk(cts_n_o, 1'h1 ^ m[0], "cts clear");
    rx_ready <= 1'h0;
    $display("test rx mode %0d done", m);
  endtask
  task automatic conclude;
    $display("counts run %0d bad %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    conclude;
  end
  initial begin
    seed = 61;
    n_mismatch = 0;
    tests_run = 0;
    {psel, penable, pwrite, tx_valid, rx_ready, fc_en, hold} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_data = 8'h00;
    presetn = 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h364, "baud reset");
    apb(1'h0, 12'h00C, 32'h0);
    chk(err, 1'h1, "unmapped");
    chk(cts_oe_n, 1'h1, "cts idle");
    foreach (e[j]) begin
      bv = j == 0 ? 32'h5 : (j == 1 ? 32'hFFFF : 32'h6C);
      apb(1'h1, 12'h004, bv);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd, clamp(bv), "baud clamp");
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) tx_case(i[1:0]);
    rx_case(HS_RTS, 1'h1);
    rx_case(HS_RTSCTS, 1'h1);
    rx_case(HS_CTS, 1'h0);
    rx_case(HS_DISABLED, 1'h0);
    conclude;
  end
endmodule // serial_port_hw_flow_control_bench
